// ---- design/egress_sched_regs.svh ----
// register offsets, fixed field values and bit positions of the scheduling slice
`ifndef EGRESS_SCHED_REGS_SVH
`define EGRESS_SCHED_REGS_SVH
// ======================================================================
// offsets
`define OFS_HP_RESERVE_Q3 8'hA7
`define OFS_HP_RESERVE_Q2 8'hA8
`define OFS_HP_RESERVE_Q1 8'hA9
`define OFS_HP_RESERVE_Q0 8'hAA
`define OFS_MEM_FLOW_M1   8'hAB
`define OFS_MEM_FLOW_M2   8'hAC
`define OFS_MEM_FLOW_M3   8'hAD
`define OFS_MEM_FLOW_M4   8'hAE
`define OFS_P1_Q3_SEL     8'hAF
`define OFS_P1_Q2_SEL     8'hB0
`define OFS_P1_Q1_SEL     8'hB1
`define OFS_P1_Q0_SEL     8'hB2
`define OFS_P2_Q3_SEL     8'hB3
`define OFS_P2_Q2_SEL     8'hB4
// ======================================================================
// fixed read-only values
`define VAL_HP_RESERVE_Q3 8'h45
`define VAL_HP_RESERVE_Q2 8'h35
`define VAL_HP_RESERVE_Q1 8'h25
`define VAL_HP_RESERVE_Q0 8'h15
`define VAL_MEM_FLOW_M1   8'h98
`define VAL_MEM_FLOW_M2   8'h10
`define VAL_MEM_FLOW_M3   8'h08
`define VAL_MEM_FLOW_M4   8'h05
`define WEIGHT_Q3         7'h08
`define WEIGHT_Q2         7'h04
`define WEIGHT_Q1         7'h02
`define WEIGHT_Q0         7'h01
// ======================================================================
// select bit field
`define SEL_BIT           7
`define SEL_RESET         6'h3F
`define READ_UNMAPPED     8'h00
`endif

// ---- design/egress_sched_pkg.sv ----
// shared types of the egress queue scheduling slice
package egress_sched_pkg;
  typedef enum logic [0:0] {
    SCHED_IDLE,
    SCHED_OFFER
  } sched_state_t;
endpackage

// ---- design/egress_queue_scheduling_config.sv ----
// egress queue scheduling registers, two schedulers and their egress fifos
//
// Notes on behaviour
// R01 - all selects and global clear: strict priority
// R02 - selects set, four queues: weights 8:4:2:1
// R03 - selects set, two queues: weights 2:1
// R04 - select bit 7 writable, resets to 1
// R05 - bits 6..0 fixed 8,4,2,1 per queue
// R06 - buffer reserve reads 45,35,25,15 hex
// R07 - flow thresholds 18,10,08,05 hex; M1 bit7 one
// R08 - writes to fixed fields are ignored
`timescale 1ns/1ns
`include "egress_sched_regs.svh"

// ======================================================================
// egress fifo with registered head
module egress_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         core_clk,  // switch core clock
  input  wire logic         reset_n,   // async reset, low
  input  wire logic         ce,        // clock enable
  input  wire logic         in_valid,  // write request
  input  wire logic [W-1:0] in_data,   // write word
  output logic              in_ready,  // room left
  output logic              out_valid, // head holds a word
  output logic [W-1:0]      out_data,  // head word
  input  wire logic         out_ready  // drain accepts head
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
    logic                    rdy;
    logic                    hv;
    logic [W-1:0]            head;
  } fifo_state_t;
  fifo_state_t cur;
  fifo_state_t next_cur;
  logic        push;
  logic        pull;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  // pointer and count update; head refills from the array
  always_comb begin
    next_cur = cur;
    push     = in_valid && cur.rdy;
    pull     = (!cur.hv || out_ready) && cur.cnt != '0;
    if (push) begin
      next_cur.mem[cur.wr] = in_data;
      next_cur.wr          = cur.wr + AW'(1);
    end
    if (!cur.hv || out_ready) begin
      next_cur.hv = pull;
    end
    if (pull) begin
      next_cur.head = cur.mem[cur.rd];
      next_cur.rd   = cur.rd + AW'(1);
    end
    next_cur.cnt = cur.cnt + (AW+1)'(push) - (AW+1)'(pull);
    next_cur.rdy = next_cur.cnt != (AW+1)'(DEPTH);
  end

  // state register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur     <= '0;
      cur.rdy <= 1'b1;
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  assign in_ready  = cur.rdy;
  assign out_valid = cur.hv;
  assign out_data  = cur.head;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_no_overflow;
    cur.cnt == (AW+1)'(DEPTH) |-> !in_ready;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("fifo full but ready");
  c_fifo_full: cover property (cur.cnt == (AW+1)'(DEPTH));
endmodule

// ======================================================================
// queue scheduler: strict or weighted credit round
module egress_sched #(
  parameter int NQ = 4,
  parameter int W  = 8,
  parameter int WW = 7
) (
  input  wire logic                   core_clk, // switch core clock
  input  wire logic                   reset_n,  // async reset, low
  input  wire logic                   ce,       // clock enable
  input  wire logic                   strict,   // strict priority mode
  input  wire logic [NQ-1:0][WW-1:0]  weights,  // per-queue weight, top index first
  input  wire logic [NQ-1:0]          q_valid,  // queue head ready to send
  input  wire logic [NQ-1:0][W-1:0]   q_data,   // queue head words
  output logic      [NQ-1:0]          q_ready,  // one-hot grant, one cycle
  input  wire logic                   room,     // fifo can take a word
  output logic                        push,     // word moves to fifo
  output logic      [W-1:0]           push_data // moved word
);
  typedef struct packed {
    egress_sched_pkg::sched_state_t st;
    logic [NQ-1:0]                  ready;
    logic [NQ-1:0][WW-1:0]          credit;
  } sched_regs_t;
  sched_regs_t       cur;
  sched_regs_t       next_cur;
  logic [NQ-1:0]     has_credit;
  logic [NQ-1:0]     cand;
  logic [NQ-1:0]     pick;
  logic              reload;
  logic [NQ-1:0][WW-1:0] base;

  if (NQ < 2 || WW < 1) begin : g_bad_cfg
    $error("scheduler needs two queues and a weight field");
  end

  // grant selection; a grant is offered for one cycle, then idle
  always_comb begin
    next_cur = cur;
    pick     = '0;
    reload   = 1'b0;
    base     = cur.credit;
    for (int i = 0; i < NQ; i++) begin
      has_credit[i] = q_valid[i] && cur.credit[i] != '0;
    end
    cand = strict ? q_valid : has_credit; // R01
    if (!strict && has_credit == '0) begin
      reload = |q_valid;                  // R02 R03
      base   = weights;
      cand   = q_valid;
    end
    if (cur.st == egress_sched_pkg::SCHED_IDLE) begin
      if (room && |q_valid) begin
        for (int i = 0; i < NQ; i++) begin
          if (cand[i]) begin
            pick    = '0;
            pick[i] = 1'b1; // highest index wins
          end
        end
        if (!strict) begin
          next_cur.credit = base;
          for (int i = 0; i < NQ; i++) begin
            if (pick[i]) begin
              next_cur.credit[i] = base[i] - WW'(1); // R02 R03
            end
          end
        end
        next_cur.ready = pick;
        next_cur.st    = egress_sched_pkg::SCHED_OFFER;
      end
    end else begin
      next_cur.ready = '0;
      next_cur.st    = egress_sched_pkg::SCHED_IDLE;
    end
  end

  // state register; credits start empty so the first round reloads
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  // transfer happens while the grant is up and the source still holds valid
  always_comb begin
    push_data = '0;
    for (int i = 0; i < NQ; i++) begin
      if (cur.ready[i]) begin
        push_data = q_data[i];
      end
    end
  end
  assign push    = |(cur.ready & q_valid);
  assign q_ready = cur.ready;

  // helper: queues above the granted one, and grants in the current round
  logic [NQ-1:0] above_grant;
  logic [7:0]    round_cnt;
  logic [7:0]    weight_sum;
  assign above_grant = ~((q_ready << 1) - NQ'(1));
  always_comb begin
    weight_sum = '0;
    for (int i = 0; i < NQ; i++) begin
      weight_sum = weight_sum + 8'(weights[i]);
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      round_cnt <= '0;
    // strict grants leave the credits alone, so they must not age the round
    end else if (ce && !strict && cur.st == egress_sched_pkg::SCHED_IDLE && |pick) begin
      round_cnt <= reload ? 8'h01 : round_cnt + 8'h01;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_strict_highest;
    ce && strict && cur.st == egress_sched_pkg::SCHED_IDLE && room && |q_valid
      |=> $onehot(q_ready) && ($past(q_valid) & above_grant) == '0;
  endproperty
  a_strict_highest: assert property (p_strict_highest) // R01
    else $error("strict grant skipped a higher queue");

  property p_round_bound;
    ce && reload && cur.st == egress_sched_pkg::SCHED_IDLE && room |-> round_cnt <= weight_sum;
  endproperty
  a_round_bound: assert property (p_round_bound) // R02 R03
    else $error("weighted round exceeded its weights");

  property p_reload_empty;
    reload |-> !strict && (q_valid & has_credit) == '0;
  endproperty
  a_reload_empty: assert property (p_reload_empty) // R02 R03
    else $error("credits reloaded while some remained");

  property p_grant_pulse;
    |q_ready && ce |=> q_ready == '0 ##1 1'b1;
  endproperty
  a_grant_pulse: assert property (p_grant_pulse) // R01
    else $error("grant held longer than one cycle");

  c_strict: cover property (strict && |q_ready);
  c_reload: cover property (ce && reload && room);
endmodule

// ======================================================================
// top: register slice and the two egress schedulers
module egress_queue_scheduling_config #(
  parameter int DATA_W     = 8,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                core_clk,    // switch core clock, 100 MHz
  input  wire logic                reset_n,     // async reset, low
  input  wire logic                ce,          // clock enable, freezes state
  input  wire logic [7:0]          reg_addr,    // register offset
  input  wire logic                reg_wr,      // write strobe
  input  wire logic [7:0]          reg_wdata,   // write byte
  input  wire logic                reg_rd,      // read strobe
  output logic      [7:0]          reg_rdata,   // read byte, registered
  output logic                     reg_rvalid,  // read data pulse
  input  wire logic                global_sched,// global scheduling control bit
  input  wire logic [3:0]          p1_q_valid,  // port 1 queue heads, q3..q0
  input  wire logic [4*DATA_W-1:0] p1_q_data,   // port 1 queue words, q3 top
  output logic      [3:0]          p1_q_ready,  // port 1 grant
  output logic                     p1_tx_valid, // port 1 egress word valid
  output logic      [DATA_W-1:0]   p1_tx_data,  // port 1 egress word
  input  wire logic                p1_tx_ready, // port 1 transmit accepts
  input  wire logic [1:0]          p2_q_valid,  // port 2 queue heads, q3,q2
  input  wire logic [2*DATA_W-1:0] p2_q_data,   // port 2 queue words, q3 top
  output logic      [1:0]          p2_q_ready,  // port 2 grant
  output logic                     p2_tx_valid, // port 2 egress word valid
  output logic      [DATA_W-1:0]   p2_tx_data,  // port 2 egress word
  input  wire logic                p2_tx_ready  // port 2 transmit accepts
);
  typedef struct packed {
    logic [5:0] sel;    // p1 q3,q2,q1,q0 then p2 q3,q2 in bits 0..5
    logic [7:0] rdata;
    logic       rvalid;
  } cfg_regs_t;
  cfg_regs_t  cur;
  cfg_regs_t  next_cur;
  logic       p1_room;
  logic       p2_room;
  logic       p1_push;
  logic       p2_push;
  logic [DATA_W-1:0] p1_word;
  logic [DATA_W-1:0] p2_word;
  logic       p1_strict;
  logic       p2_strict;

  if (DATA_W < 1) begin : g_bad_width
    $error("data width must be at least one bit");
  end

  // read mux: select bit over fixed weight field
  function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [5:0] s);
    case (a)
      `OFS_HP_RESERVE_Q3: read_reg = `VAL_HP_RESERVE_Q3; // R06
      `OFS_HP_RESERVE_Q2: read_reg = `VAL_HP_RESERVE_Q2;
      `OFS_HP_RESERVE_Q1: read_reg = `VAL_HP_RESERVE_Q1;
      `OFS_HP_RESERVE_Q0: read_reg = `VAL_HP_RESERVE_Q0;
      `OFS_MEM_FLOW_M1:   read_reg = `VAL_MEM_FLOW_M1;   // R07
      `OFS_MEM_FLOW_M2:   read_reg = `VAL_MEM_FLOW_M2;
      `OFS_MEM_FLOW_M3:   read_reg = `VAL_MEM_FLOW_M3;
      `OFS_MEM_FLOW_M4:   read_reg = `VAL_MEM_FLOW_M4;
      `OFS_P1_Q3_SEL:     read_reg = {s[0], `WEIGHT_Q3}; // R05
      `OFS_P1_Q2_SEL:     read_reg = {s[1], `WEIGHT_Q2};
      `OFS_P1_Q1_SEL:     read_reg = {s[2], `WEIGHT_Q1};
      `OFS_P1_Q0_SEL:     read_reg = {s[3], `WEIGHT_Q0};
      `OFS_P2_Q3_SEL:     read_reg = {s[4], `WEIGHT_Q3};
      `OFS_P2_Q2_SEL:     read_reg = {s[5], `WEIGHT_Q2};
      default:            read_reg = `READ_UNMAPPED;
    endcase
  endfunction

  // register writes touch only bit 7 of the select registers
  always_comb begin
    next_cur        = cur;
    next_cur.rvalid = reg_rd;
    if (reg_rd) begin
      next_cur.rdata = read_reg(reg_addr, cur.sel);
    end
    if (reg_wr) begin
      case (reg_addr)
        `OFS_P1_Q3_SEL: next_cur.sel[0] = reg_wdata[`SEL_BIT]; // R04
        `OFS_P1_Q2_SEL: next_cur.sel[1] = reg_wdata[`SEL_BIT];
        `OFS_P1_Q1_SEL: next_cur.sel[2] = reg_wdata[`SEL_BIT];
        `OFS_P1_Q0_SEL: next_cur.sel[3] = reg_wdata[`SEL_BIT];
        `OFS_P2_Q3_SEL: next_cur.sel[4] = reg_wdata[`SEL_BIT];
        `OFS_P2_Q2_SEL: next_cur.sel[5] = reg_wdata[`SEL_BIT];
        default:        next_cur.sel    = cur.sel; // R08
      endcase
    end
  end

  // state register; weighted scheduling is the reset default
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur     <= '0;
      cur.sel <= `SEL_RESET; // R04
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  assign reg_rdata  = cur.rdata;
  assign reg_rvalid = cur.rvalid;
  // strict only when every select of the port and the global bit are clear
  assign p1_strict  = cur.sel[3:0] == 4'h0 && !global_sched; // R01
  assign p2_strict  = cur.sel[5:4] == 2'h0 && !global_sched; // R01

  // ======================================================================
  // port 1: four queues, weights from the fixed fields 8:4:2:1
  egress_sched #(.NQ(4), .W(DATA_W), .WW(7)) u_p1_sched (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .ce        (ce),
    .strict    (p1_strict),
    .weights   ({`WEIGHT_Q3, `WEIGHT_Q2, `WEIGHT_Q1, `WEIGHT_Q0}), // R02
    .q_valid   (p1_q_valid),
    .q_data    (p1_q_data),
    .q_ready   (p1_q_ready),
    .room      (p1_room),
    .push      (p1_push),
    .push_data (p1_word)
  );
  egress_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_p1_fifo (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .ce        (ce),
    .in_valid  (p1_push),
    .in_data   (p1_word),
    .in_ready  (p1_room),
    .out_valid (p1_tx_valid),
    .out_data  (p1_tx_data),
    .out_ready (p1_tx_ready)
  );

  // ======================================================================
  // port 2: two queues; fields 8 and 4 give the 2:1 share
  egress_sched #(.NQ(2), .W(DATA_W), .WW(7)) u_p2_sched (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .ce        (ce),
    .strict    (p2_strict),
    .weights   ({`WEIGHT_Q3, `WEIGHT_Q2}), // R03
    .q_valid   (p2_q_valid),
    .q_data    (p2_q_data),
    .q_ready   (p2_q_ready),
    .room      (p2_room),
    .push      (p2_push),
    .push_data (p2_word)
  );
  egress_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_p2_fifo (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .ce        (ce),
    .in_valid  (p2_push),
    .in_data   (p2_word),
    .in_ready  (p2_room),
    .out_valid (p2_tx_valid),
    .out_data  (p2_tx_data),
    .out_ready (p2_tx_ready)
  );

  // ======================================================================
  // checks on the register slice
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_sel_reset;
    $rose(reset_n) |-> cur.sel == `SEL_RESET;
  endproperty
  a_sel_reset: assert property (p_sel_reset) // R04
    else $error("select bits not set after reset");

  property p_sel_write;
    ce && reg_wr && reg_addr == `OFS_P1_Q3_SEL |=> cur.sel[0] == $past(reg_wdata[7]);
  endproperty
  a_sel_write: assert property (p_sel_write) // R04
    else $error("select bit did not follow the write");

  property p_weight_read;
    ce && reg_rd && reg_addr == `OFS_P2_Q2_SEL && !reg_wr
      |=> reg_rvalid && reg_rdata[6:0] == `WEIGHT_Q2 && reg_rdata[7] == cur.sel[5];
  endproperty
  a_weight_read: assert property (p_weight_read) // R05
    else $error("queue select register read wrong");

  property p_reserve_read;
    ce && reg_rd && reg_addr == `OFS_HP_RESERVE_Q1 |=> reg_rdata == 8'h25;
  endproperty
  a_reserve_read: assert property (p_reserve_read) // R06
    else $error("buffer reserve read wrong");

  property p_flow_read;
    ce && reg_rd && reg_addr == `OFS_MEM_FLOW_M1 |=> reg_rdata == 8'h98 ##1 1'b1;
  endproperty
  a_flow_read: assert property (p_flow_read) // R07
    else $error("flow threshold read wrong");

  property p_ro_write;
    reg_wr && reg_addr < `OFS_P1_Q3_SEL |=> $stable(cur.sel);
  endproperty
  a_ro_write: assert property (p_ro_write) // R08
    else $error("write to a fixed register changed state");

  c_sel_clear: cover property (ce && reg_wr && reg_wdata[7] == 1'b0);
  c_p1_strict: cover property (p1_strict && |p1_q_ready);
endmodule

// ---- test/egress_port_model.sv ----
// behavioural queue sources and transmit sink standing at one egress port
`timescale 1ns/1ns
module egress_port_model #(
  parameter int NQ = 4
) (
  input  wire logic          core_clk, // switch core clock
  input  wire logic          reset_n,  // async reset, low
  input  wire logic          stall,    // hold the sink off
  input  wire logic [31:0]   limit,    // grants allowed in total
  output logic [NQ-1:0]      q_valid,  // queue heads present
  output logic [NQ*8-1:0]    q_data,   // queue words, top queue high
  input  wire logic [NQ-1:0] q_ready,  // grants from the scheduler
  input  wire logic          tx_valid, // egress word valid
  input  wire logic [7:0]    tx_data,  // egress word
  output logic               tx_ready  // sink accepts
);
  int         total = 0;
  int         bad = 0;
  int         granted [NQ] = '{default: 0};
  logic [7:0] sent [$];
  initial tx_ready = 1'b0;
  // ======================================================================
  // queues stay backlogged until the budget runs out, so valid only
  // falls after a grant and never under one
  always_comb begin
    q_valid = (total < limit) ? {NQ{1'b1}} : '0;
    for (int i = 0; i < NQ; i++) begin
      q_data[i*8 +: 8] = 8'hA0 + 8'(i);
    end
  end
  // ======================================================================
  // grant bookkeeping and in-order check of the egress words
  always @(posedge core_clk) begin
    tx_ready <= !stall;
    for (int i = 0; i < NQ; i++) begin
      if (q_ready[i] === 1'b1) begin
        granted[i] = granted[i] + 1;
        sent.push_back(8'hA0 + 8'(i));
      end
    end
    total <= total + $countones(q_ready);
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (sent.size() == 0 || tx_data !== sent.pop_front()) begin
        bad <= bad + 1;
      end
    end
  end
endmodule

// ---- test/tb.sv ----
// self-checking bench of the egress scheduling slice
`timescale 1ns/1ns
module tb;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        global_sched = 1'b0;
  logic [3:0]  p1_q_valid, p1_q_ready;
  logic [31:0] p1_q_data;
  logic [1:0]  p2_q_valid, p2_q_ready;
  logic [15:0] p2_q_data;
  logic        p1_tx_valid, p1_tx_ready, p2_tx_valid, p2_tx_ready;
  logic [7:0]  p1_tx_data, p2_tx_data;
  logic        stall1 = 1'b0;
  int          lim1 = 0;
  int          lim2 = 0;
  int          err_total = 0;
  int          checked = 0;
  int          b1 [4];
  int          b2 [2];
  logic [7:0]  rst_val [14] = '{8'h45, 8'h35, 8'h25, 8'h15, 8'h98, 8'h10, 8'h08,
                                8'h05, 8'h88, 8'h84, 8'h82, 8'h81, 8'h88, 8'h84};

  egress_queue_scheduling_config uut (.core_clk, .reset_n, .ce(1'b1), .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .global_sched, .p1_q_valid, .p1_q_data,
    .p1_q_ready, .p1_tx_valid, .p1_tx_data, .p1_tx_ready, .p2_q_valid, .p2_q_data,
    .p2_q_ready, .p2_tx_valid, .p2_tx_data, .p2_tx_ready);
  egress_port_model #(.NQ(4)) p1 (.core_clk, .reset_n, .stall(stall1), .limit(lim1),
    .q_valid(p1_q_valid), .q_data(p1_q_data), .q_ready(p1_q_ready),
    .tx_valid(p1_tx_valid), .tx_data(p1_tx_data), .tx_ready(p1_tx_ready));
  egress_port_model #(.NQ(2)) p2 (.core_clk, .reset_n, .stall(1'b0), .limit(lim2),
    .q_valid(p2_q_valid), .q_data(p2_q_data), .q_ready(p2_q_ready),
    .tx_valid(p2_tx_valid), .tx_data(p2_tx_data), .tx_ready(p2_tx_ready));

  // ======================================================================
  // clock, 10 ns period
  always #5 core_clk = ~core_clk;

  // ======================================================================
  // compare tasks and register access
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_count(input int got, input int exp, input string what);
    checked++;
    if (got != exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask
  // strobe for one edge; the answer is registered on the edge that takes it
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    cmp_byte({7'h00, reg_rvalid}, 8'h01, "read valid");
    cmp_byte(reg_rdata, exp, "read data");
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // bounded wait for both grant budgets, then let the fifos drain
  task automatic run_until(input int a, input int b);
    int n;
    n = 0;
    while ((p1.total < a || p2.total < b) && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    cmp_count(int'(n < 3000), 1, "grant budget reached");
    repeat (60) @(posedge core_clk);
  endtask
  task automatic snap;
    b1 = p1.granted;
    b2 = p2.granted;
  endtask
  task automatic chk(input int e1 [4], input int e2 [2]);
    for (int i = 0; i < 4; i++) begin
      cmp_count(p1.granted[i] - b1[i], e1[i], "port 1 grants");
    end
    for (int i = 0; i < 2; i++) begin
      cmp_count(p2.granted[i] - b2[i], e2[i], "port 2 grants");
    end
  endtask
  task automatic close_out;
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ======================================================================
  // watchdog: the sequence needs under 10k cycles, give it 50k
  initial begin
    #500000;
    err_total++;
    close_out();
  end

  // ======================================================================
  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      rd(8'hA7 + 8'(i), rst_val[i]);
    end
    rd(8'hA6, 8'h00);
    rd(8'hB5, 8'h00);
    // weighted from reset, all queues backlogged
    snap();
    lim1 <= 15;
    lim2 <= 12;
    run_until(15, 12);
    chk('{1, 2, 4, 8}, '{4, 8});
    // sink stalled: head plus sixteen words, then drain in order
    stall1 <= 1'b1;
    lim1 <= 55;
    repeat (200) @(posedge core_clk);
    cmp_count(p1.total, 32, "grants into full fifo");
    cmp_byte({7'h00, p1_tx_valid}, 8'h01, "stalled head");
    stall1 <= 1'b0;
    run_until(55, 12);
    cmp_byte({7'h00, p1_tx_valid}, 8'h00, "drained");
    cmp_count(p1.bad + p2.bad, 0, "egress word order");
    // fixed fields ignore writes, select bits clear
    for (int i = 0; i < 14; i++) begin
      wr(8'hA7 + 8'(i), 8'h7F);
    end
    for (int i = 0; i < 14; i++) begin
      rd(8'hA7 + 8'(i), (i < 8) ? rst_val[i] : (rst_val[i] & 8'h7F));
    end
    // all selects and global bit clear: highest queue only
    snap();
    lim1 <= 65;
    lim2 <= 18;
    run_until(65, 18);
    chk('{0, 0, 0, 10}, '{0, 6});
    // global bit set overrides strict order
    global_sched <= 1'b1;
    snap();
    lim1 <= 80;
    lim2 <= 30;
    run_until(80, 30);
    cmp_count(int'(p1.granted[3] - b1[3] < 15), 1, "port 1 lower queues served");
    cmp_count(int'(p2.granted[0] - b2[0] > 0), 1, "port 2 lower queue served");
    cmp_count(p1.bad + p2.bad, 0, "egress word order");
    close_out();
  end
endmodule
